// ---- bvs_pkg.sv ----
// constants, field layout and types for the button value select and send block
// assumes a 25 MHz clock and a 32-bit apb register bus with 12-bit byte addresses
package bvs_pkg;
  localparam int NUM_SLOTS = 20;
  localparam logic [4:0] NUM_SLOTS_5 = 5'h14;
  localparam logic [3:0] LIST_MIN = 4'h2;
  localparam logic [3:0] LIST_MAX = 4'hC;
  localparam logic [3:0] PRIO_LIST_MAX = 4'h3;
  localparam logic [3:0] HVAC_LIST_MAX = 4'h5;
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [15:0] SEND_DELAY_MS_RESET = 16'h03E8;
  // global registers, region 0
  localparam logic [4:0] W_CTRL = 5'h00;
  localparam logic [4:0] W_DELAY = 5'h01;
  localparam logic [4:0] W_STATUS = 5'h02;
  // per-slot words, slot n in region n+1 (stride 0x80)
  localparam logic [4:0] W_CFG = 5'h00;
  localparam logic [4:0] W_MIN = 5'h01;
  localparam logic [4:0] W_MAX = 5'h02;
  localparam logic [4:0] W_STEP = 5'h03;
  localparam logic [4:0] W_FIX_TOP = 5'h04;
  localparam logic [4:0] W_FIX_BOT = 5'h05;
  localparam logic [4:0] W_VALUE = 5'h06;
  localparam logic [4:0] W_LIST = 5'h10;
  localparam logic [4:0] W_LIST_END = 5'h1B;
  localparam int CTRL_DELAY_EN_BIT = 0;
  localparam int CTRL_REVERSE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_FUNC_LSB = 4;
  localparam int CFG_LEN_LSB = 8;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [7:0] MIN_RESET = 8'h00;
  localparam logic [7:0] MAX_RESET = 8'hFF;
  localparam logic [7:0] STEP_RESET = 8'h01;
  typedef enum logic [1:0] {MODE_FIXED, MODE_LIST, MODE_MOVE} bvs_mode_e;
  typedef enum logic [3:0] {FN_SWITCH, FN_DIM, FN_BLIND, FN_PRIO, FN_BYTE, FN_PERCENT,
                            FN_FLOAT, FN_HVAC, FN_SCENE, FN_CTEMP, FN_COLOUR} bvs_func_e;
  typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_WAIT} bvs_state_e;
endpackage : bvs_pkg

// ---- bvs_timer_if.sv ----
// handshake between the send sequencer and the send delay timer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface bvs_timer_if;
  logic start;
  logic cancel;
  logic [15:0] delay_ms;
  logic expired;
  modport ctrl (output start, output cancel, output delay_ms, input expired);
  modport timer (input start, input cancel, input delay_ms, output expired);
endinterface : bvs_timer_if

// ---- bvs_send_timer.sv ----
// send delay timer: millisecond enable from a divider, then a millisecond count
// assumes start and cancel are single-cycle pulses from the sequencer
`timescale 1ns/1ps
module bvs_send_timer #(
  parameter int CYCLES_PER_MS = bvs_pkg::CYCLES_PER_MS
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  bvs_timer_if.timer tif
);
  logic running;
  logic [15:0] cyc_cnt;
  logic [15:0] ms_cnt;
  logic ms_tick;

  assign ms_tick = running && (cyc_cnt == 16'(CYCLES_PER_MS - 1));

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_cnt <= 16'h0000;
    end else if (tif.start || tif.cancel || ms_tick || !running) begin
      cyc_cnt <= 16'h0000;
    end else begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end

  // a zero delay still waits for the first tick so the release is seen first
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      running <= 1'b0;
      ms_cnt <= 16'h0000;
      tif.expired <= 1'b0;
    end else begin
      tif.expired <= 1'b0;
      if (tif.cancel) begin
        running <= 1'b0;
      end else if (tif.start) begin
        running <= 1'b1;
        ms_cnt <= 16'h0000;
      end else if (ms_tick) begin
        ms_cnt <= ms_cnt + 16'h0001;
        if ((ms_cnt + 16'h0001) >= tif.delay_ms) begin
          running <= 1'b0;
          tif.expired <= 1'b1;
        end
      end
    end
  end
endmodule : bvs_send_timer

// ---- bvs_value_select.sv ----
// Operation
// - each of twenty button functions has its own operating mode
// - fixed values: each button carries and sends its own value
// - switching, dimming, blinds forced to fixed values; others may choose it
// - fixed values send one telegram at once on every press
// - value list only for priority, byte, percent, float, hvac, scene, colours; the code also allows it for colour temperature
// - value list holds two to twelve entries
// - list capped at three for priority and five for hvac
// - top or bottom press steps display to next list entry
// - list and move modes send with or without delay, configurable
// - delay defaults to one second; scrolling only updates the display
// - with delay, send final value after release and delay expiry
// - without delay, every displayed value is sent at once
// - move value only for byte, percent, float and colour temperature
// - move value steps within configured minimum and maximum
// top of the value select and send block: apb registers, button pins, telegram strobe
// assumes button pins are asynchronous and i_slot comes from same-clock menu logic
`timescale 1ns/1ps
module bvs_value_select #(
  parameter int CYCLES_PER_MS = bvs_pkg::CYCLES_PER_MS
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_button_top,
  input wire logic i_button_bottom,
  input wire logic [4:0] i_slot,
  output logic [7:0] o_display_value,
  output logic o_tx_valid,
  output logic [4:0] o_tx_slot,
  output logic [7:0] o_tx_value
);
  localparam int N = bvs_pkg::NUM_SLOTS;

  logic [1:0] ctrl;
  logic [15:0] delay_ms;
  logic [11:0] cfg [N];
  logic [7:0] vmin [N];
  logic [7:0] vmax [N];
  logic [7:0] vstep [N];
  logic [7:0] fix_top [N];
  logic [7:0] fix_bot [N];
  logic [7:0] list [N][12];
  logic [7:0] cur_val [N];
  logic [3:0] cur_idx [N];
  logic [1:0] top_sync;
  logic [1:0] bot_sync;
  logic top_prev;
  logic bot_prev;
  bvs_pkg::bvs_state_e state;
  logic [4:0] pend_slot;
  logic [7:0] pend_val;
  bvs_timer_if tif ();

  // are enforced here so software cannot select an illegal mode
  function automatic bvs_pkg::bvs_mode_e eff_mode(input logic [11:0] c);
    bvs_pkg::bvs_mode_e m;
    m = bvs_pkg::MODE_FIXED;
    case (c[bvs_pkg::CFG_FUNC_LSB +: 4])
      bvs_pkg::FN_BYTE, bvs_pkg::FN_PERCENT, bvs_pkg::FN_FLOAT, bvs_pkg::FN_CTEMP: begin
        if (c[bvs_pkg::CFG_MODE_LSB +: 2] == bvs_pkg::MODE_LIST) m = bvs_pkg::MODE_LIST;
        if (c[bvs_pkg::CFG_MODE_LSB +: 2] == bvs_pkg::MODE_MOVE) m = bvs_pkg::MODE_MOVE;
      end
      bvs_pkg::FN_PRIO, bvs_pkg::FN_HVAC, bvs_pkg::FN_SCENE, bvs_pkg::FN_COLOUR: begin
        if (c[bvs_pkg::CFG_MODE_LSB +: 2] == bvs_pkg::MODE_LIST) m = bvs_pkg::MODE_LIST;
      end
      default: m = bvs_pkg::MODE_FIXED;
    endcase
    return m;
  endfunction : eff_mode

  function automatic logic [3:0] eff_len(input logic [11:0] c);
    logic [3:0] l;
    l = c[bvs_pkg::CFG_LEN_LSB +: 4];
    if (l < bvs_pkg::LIST_MIN) l = bvs_pkg::LIST_MIN;
    if (l > bvs_pkg::LIST_MAX) l = bvs_pkg::LIST_MAX;
    if (c[bvs_pkg::CFG_FUNC_LSB +: 4] == bvs_pkg::FN_PRIO && l > bvs_pkg::PRIO_LIST_MAX)
      l = bvs_pkg::PRIO_LIST_MAX;
    if (c[bvs_pkg::CFG_FUNC_LSB +: 4] == bvs_pkg::FN_HVAC && l > bvs_pkg::HVAC_LIST_MAX)
      l = bvs_pkg::HVAC_LIST_MAX;
    return l;
  endfunction : eff_len

  // region 0 holds globals, region n+1 holds slot n
  function automatic logic addr_ok(input logic [11:0] a);
    logic [4:0] r;
    logic [4:0] w;
    r = a[11:7];
    w = a[6:2];
    if (r == 5'h00) return w <= bvs_pkg::W_STATUS;
    if (r > bvs_pkg::NUM_SLOTS_5) return 1'b0;
    return (w <= bvs_pkg::W_VALUE) || (w >= bvs_pkg::W_LIST && w <= bvs_pkg::W_LIST_END);
  endfunction : addr_ok

  // apb: one wait state, so pready is a plain flop
  logic wr_en;
  logic [4:0] a_reg;
  logic [4:0] a_word;
  logic [4:0] a_slot;
  logic [3:0] a_lidx;
  logic [31:0] rd_data;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && addr_ok(i_paddr);
  assign a_reg = i_paddr[11:7];
  assign a_word = i_paddr[6:2];
  assign a_slot = (a_reg == 5'h00) ? 5'h00 : a_reg - 5'h01;
  assign a_lidx = 4'(a_word - bvs_pkg::W_LIST);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (a_reg == 5'h00) begin
      case (a_word)
        bvs_pkg::W_CTRL: rd_data = {30'h0, ctrl};
        bvs_pkg::W_DELAY: rd_data = {16'h0, delay_ms};
        bvs_pkg::W_STATUS: rd_data = {11'h0, pend_slot, 3'h0, state != bvs_pkg::ST_IDLE,
                                      4'h0, pend_val};
        default: rd_data = 32'h0000_0000;
      endcase
    end else if (a_reg <= bvs_pkg::NUM_SLOTS_5) begin
      case (a_word)
        bvs_pkg::W_CFG: rd_data = {20'h0, cfg[a_slot]};
        bvs_pkg::W_MIN: rd_data = {24'h0, vmin[a_slot]};
        bvs_pkg::W_MAX: rd_data = {24'h0, vmax[a_slot]};
        bvs_pkg::W_STEP: rd_data = {24'h0, vstep[a_slot]};
        bvs_pkg::W_FIX_TOP: rd_data = {24'h0, fix_top[a_slot]};
        bvs_pkg::W_FIX_BOT: rd_data = {24'h0, fix_bot[a_slot]};
        bvs_pkg::W_VALUE: rd_data = {24'h0, cur_val[a_slot]};
        default: if (a_lidx < 4'hC) rd_data = {24'h0, list[a_slot][a_lidx]};
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_prdata <= addr_ok(i_paddr) ? rd_data : 32'h0000_0000; // unmapped words read zero
      o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok(i_paddr);
    end
  end

  // configuration storage, one set per button function slot
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= bvs_pkg::CTRL_RESET;
      delay_ms <= bvs_pkg::SEND_DELAY_MS_RESET;
      for (int s = 0; s < N; s++) begin
        cfg[s] <= bvs_pkg::CFG_RESET;
        vmin[s] <= bvs_pkg::MIN_RESET;
        vmax[s] <= bvs_pkg::MAX_RESET;
        vstep[s] <= bvs_pkg::STEP_RESET;
        fix_top[s] <= 8'h00;
        fix_bot[s] <= 8'h00;
        for (int e = 0; e < 12; e++) list[s][e] <= 8'h00;
      end
    end else if (wr_en) begin
      if (a_reg == 5'h00) begin
        if (a_word == bvs_pkg::W_CTRL) ctrl <= i_pwdata[1:0];
        if (a_word == bvs_pkg::W_DELAY) delay_ms <= i_pwdata[15:0];
      end else begin
        case (a_word)
          bvs_pkg::W_CFG: cfg[a_slot] <= i_pwdata[11:0];
          bvs_pkg::W_MIN: vmin[a_slot] <= i_pwdata[7:0];
          bvs_pkg::W_MAX: vmax[a_slot] <= i_pwdata[7:0];
          bvs_pkg::W_STEP: vstep[a_slot] <= i_pwdata[7:0];
          bvs_pkg::W_FIX_TOP: fix_top[a_slot] <= i_pwdata[7:0];
          bvs_pkg::W_FIX_BOT: fix_bot[a_slot] <= i_pwdata[7:0];
          default: if (a_lidx < 4'hC) list[a_slot][a_lidx] <= i_pwdata[7:0];
        endcase
      end
    end
  end

  // button pins: two-flop synchroniser, then edge detect on the second stage
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      top_sync <= 2'b00;
      bot_sync <= 2'b00;
      top_prev <= 1'b0;
      bot_prev <= 1'b0;
    end else begin
      top_sync <= {top_sync[0], i_button_top};
      bot_sync <= {bot_sync[0], i_button_bottom};
      top_prev <= top_sync[1];
      bot_prev <= bot_sync[1];
    end
  end

  logic press_top;
  logic press_bot;
  logic press_any;
  logic slot_ok;
  logic [4:0] sel;
  bvs_pkg::bvs_mode_e mode_sel;
  logic [3:0] len_sel;
  logic [3:0] idx_sel;
  logic [3:0] next_idx;
  logic dir_up;
  logic [8:0] sum9;
  logic [8:0] low9;
  logic [7:0] next_val;
  logic [7:0] new_val;
  logic [7:0] fixed_val;
  logic scroll;
  logic fixed_press;
  logic delay_en;

  // simultaneous presses count as top only
  always_comb begin
    press_top = top_sync[1] && !top_prev;
    press_bot = bot_sync[1] && !bot_prev && !press_top;
    press_any = press_top || press_bot;
    slot_ok = i_slot < bvs_pkg::NUM_SLOTS_5;
    sel = slot_ok ? i_slot : 5'h00;
    mode_sel = eff_mode(cfg[sel]);
    len_sel = eff_len(cfg[sel]);
    idx_sel = (cur_idx[sel] >= len_sel) ? 4'h0 : cur_idx[sel];
    dir_up = press_top ^ ctrl[bvs_pkg::CTRL_REVERSE_BIT];
    delay_en = ctrl[bvs_pkg::CTRL_DELAY_EN_BIT];
    if (dir_up) next_idx = (idx_sel == len_sel - 4'h1) ? 4'h0 : idx_sel + 4'h1;
    else next_idx = (idx_sel == 4'h0) ? len_sel - 4'h1 : idx_sel - 4'h1;
    sum9 = {1'b0, cur_val[sel]} + {1'b0, vstep[sel]};
    low9 = {1'b0, vmin[sel]} + {1'b0, vstep[sel]};
    if (dir_up) next_val = (sum9 > {1'b0, vmax[sel]}) ? vmax[sel] : sum9[7:0];
    else next_val = ({1'b0, cur_val[sel]} < low9) ? vmin[sel] : cur_val[sel] - vstep[sel];
    new_val = (mode_sel == bvs_pkg::MODE_LIST) ? list[sel][next_idx] : next_val;
    fixed_val = press_top ? fix_top[sel] : fix_bot[sel];
    scroll = press_any && slot_ok && mode_sel != bvs_pkg::MODE_FIXED;
    fixed_press = press_any && slot_ok && mode_sel == bvs_pkg::MODE_FIXED;
  end

  // scroll position per slot; a button step wins over a register write
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int s = 0; s < N; s++) begin
        cur_val[s] <= 8'h00;
        cur_idx[s] <= 4'h0;
      end
    end else if (scroll) begin
      if (mode_sel == bvs_pkg::MODE_LIST) cur_idx[sel] <= next_idx;
      else cur_val[sel] <= next_val;
    end else if (wr_en && a_reg != 5'h00 && a_word == bvs_pkg::W_VALUE) begin
      cur_val[a_slot] <= i_pwdata[7:0];
    end
  end

  // a release starts the delay; a new scroll step restarts the wait
  logic released;
  assign released = !top_sync[1] && !bot_sync[1];
  assign tif.delay_ms = delay_ms;
  assign tif.start = (state == bvs_pkg::ST_HELD) && released && !scroll;
  assign tif.cancel = scroll && delay_en && (state == bvs_pkg::ST_WAIT);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= bvs_pkg::ST_IDLE;
      pend_slot <= 5'h00;
      pend_val <= 8'h00;
    end else if (scroll && delay_en) begin
      state <= bvs_pkg::ST_HELD;
      pend_slot <= sel;
      pend_val <= new_val;
    end else begin
      case (state)
        bvs_pkg::ST_HELD: if (released) state <= bvs_pkg::ST_WAIT;
        // a fixed press that collides with expiry defers the pending send
        bvs_pkg::ST_WAIT: if (tif.expired) begin
          state <= fixed_press ? bvs_pkg::ST_HELD : bvs_pkg::ST_IDLE;
        end
        default: state <= bvs_pkg::ST_IDLE;
      endcase
    end
  end

  bvs_send_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .tif(tif.timer)
  );

  // telegram strobe, display follows the selected slot
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_slot <= 5'h00;
      o_tx_value <= 8'h00;
    end else begin
      o_tx_valid <= 1'b0;
      if (fixed_press) begin
        o_tx_valid <= 1'b1;
        o_tx_slot <= sel;
        o_tx_value <= fixed_val;
      end else if (scroll && !delay_en) begin
        o_tx_valid <= 1'b1;
        o_tx_slot <= sel;
        o_tx_value <= new_val;
      end else if (state == bvs_pkg::ST_WAIT && tif.expired && !scroll) begin
        o_tx_valid <= 1'b1;
        o_tx_slot <= pend_slot;
        o_tx_value <= pend_val;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_display_value <= 8'h00;
    end else if (scroll) begin
      o_display_value <= new_val;
    end else if (mode_sel == bvs_pkg::MODE_LIST) begin
      o_display_value <= list[sel][idx_sel];
    end else if (mode_sel == bvs_pkg::MODE_MOVE) begin
      o_display_value <= cur_val[sel];
    end else begin
      o_display_value <= fix_top[sel];
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_fixed_now;
    fixed_press |=> o_tx_valid && o_tx_value == $past(fixed_val) && o_tx_slot == $past(sel);
  endproperty
  a_fixed_now: assert property (p_fixed_now) else $error("fixed press not sent");
  property p_nodelay_send;
    scroll && !delay_en |=> o_tx_valid && o_tx_value == o_display_value;
  endproperty
  a_nodelay_send: assert property (p_nodelay_send) else $error("scroll not sent");
  property p_delay_silent;
    scroll && delay_en |=> !o_tx_valid ##1 !o_tx_valid;
  endproperty
  a_delay_silent: assert property (p_delay_silent) else $error("sent while scrolling");
  property p_expiry_send;
    state == bvs_pkg::ST_WAIT && tif.expired && !press_any |=>
      o_tx_valid && o_tx_value == $past(pend_val) && state == bvs_pkg::ST_IDLE;
  endproperty
  a_expiry_send: assert property (p_expiry_send) else $error("final value lost");
  property p_range;
    scroll && mode_sel == bvs_pkg::MODE_MOVE && vmin[sel] <= vmax[sel] |=>
      o_display_value >= $past(vmin[sel]) && o_display_value <= $past(vmax[sel]);
  endproperty
  a_range: assert property (p_range) else $error("move value out of range");
  property p_len;
    len_sel >= 4'h2 && len_sel <= 4'hC;
  endproperty
  a_len: assert property (p_len) else $error("list length out of range");
  property p_len_cap;
    cfg[sel][7:4] == bvs_pkg::FN_PRIO |-> len_sel <= 4'h3;
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("priority list too long");
  property p_forced_fixed;
    cfg[sel][7:4] <= bvs_pkg::FN_BLIND |-> mode_sel == bvs_pkg::MODE_FIXED;
  endproperty
  a_forced_fixed: assert property (p_forced_fixed) else $error("mode not forced");
  property p_list_step;
    scroll && mode_sel == bvs_pkg::MODE_LIST && dir_up && idx_sel < len_sel - 4'h1 |=>
      cur_idx[$past(sel)] == $past(idx_sel) + 4'h1;
  endproperty
  a_list_step: assert property (p_list_step) else $error("list did not advance");
  c_fixed: cover property (fixed_press);
  c_delayed: cover property (state == bvs_pkg::ST_WAIT && tif.expired);
  c_clamp: cover property (scroll && mode_sel == bvs_pkg::MODE_MOVE && next_val == vmax[sel]);
endmodule : bvs_value_select

// ---- bvs_actuator.sv ----
// far-side model: telegram receivers holding one value per button function slot
// assumes a one-cycle send strobe with slot and value, same clock as the sender
`timescale 1ns/1ps
module bvs_actuator (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_tx_valid,
  input wire logic [4:0] i_tx_slot,
  input wire logic [7:0] i_tx_value,
  input wire logic [4:0] i_peek_slot,
  output logic [7:0] o_peek_value,
  output logic [15:0] o_count
);
  logic [7:0] level [20];
  // slots past the twenty functions have no receiver, so such telegrams are counted but their values are not stored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= 16'h0000;
      for (int k = 0; k < 20; k++) level[k] <= 8'h00;
    end else if (i_tx_valid) begin
      o_count <= o_count + 16'h0001;
      if (i_tx_slot < 5'h14) level[i_tx_slot] <= i_tx_value;
    end
  end
  assign o_peek_value = (i_peek_slot < 5'h14) ? level[i_peek_slot] : 8'h00;
endmodule : bvs_actuator

// ---- tb.sv ----
// self-checking bench for the value select and send block
// assumes one apb wait state and a shortened millisecond divider
`timescale 1ns/1ps
module tb;
  logic i_clock = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, btop = 0, bbot = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, txv;
  logic [4:0] slot = 5'h00, txs;
  logic [7:0] disp, txd, peek, v0, v1;
  logic [15:0] cnt;
  logic [12:0] tq[$];
  logic [32:0] rq[$];
  logic [7:0] lst[12];
  int n_fail = 0, tests_run = 0, seed = 32'ha1e7, sent = 0;
  int tn[3] = '{5, 7, 8}, tf[3] = '{3, 7, 8}, tl[3] = '{12, 12, 1}, tc[3] = '{3, 5, 2};
  logic [7:0] mv[6] = '{8'h14, 8'h18, 8'h1A, 8'h16, 8'h12, 8'h10};
  bvs_value_select #(.CYCLES_PER_MS(4)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_button_top(btop),
    .i_button_bottom(bbot), .i_slot(slot), .o_display_value(disp), .o_tx_valid(txv),
    .o_tx_slot(txs), .o_tx_value(txd));
  bvs_actuator act (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_tx_valid(txv),
    .i_tx_slot(txs), .i_tx_value(txd), .i_peek_slot(5'h06), .o_peek_value(peek),
    .o_count(cnt));
  initial forever #20 i_clock = ~i_clock;
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // request held until pready is seen at an edge; one idle cycle between transfers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pen <= 1'b0;
    @(posedge i_clock);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(k < 50, "no pready");
    psel <= 1'b0; pen <= 1'b0;
    @(posedge i_clock);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    rq.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [11:0] sa(input int n, input logic [4:0] w);
    return 12'((n + 1) * 128) + {5'h00, w, 2'b00};
  endfunction : sa
  task automatic wlist(input int n);
    for (int k = 0; k < 12; k++) apb(1'b1, sa(n, 5'(bvs_pkg::W_LIST + k)), {24'h0, lst[k]});
  endtask : wlist
  task automatic exp(input int n, input logic [7:0] v);
    tq.push_back({5'(n), v});
    sent++;
  endtask : exp
  // pins held long enough for the two-flop synchroniser and edge detect
  task automatic press(input logic top, input int n);
    slot <= 5'(n);
    if (top) btop <= 1'b1;
    else bbot <= 1'b1;
    repeat (6) @(posedge i_clock);
    btop <= 1'b0;
    bbot <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask : press
  task automatic drain;
    for (int k = 0; k < 100 && tq.size() != 0; k++) @(posedge i_clock);
    // one more edge so the receiver count of the last telegram has landed
    @(posedge i_clock);
    chk(tq.size() == 0, "telegram missing");
  endtask : drain
  always @(posedge i_clock) begin
    if (txv === 1'b1) begin
      if (tq.size() == 0) chk(1'b0, "unexpected telegram");
      else chk({txs, txd} === tq.pop_front(), "telegram mismatch");
    end
    if (pready === 1'b1 && pwr === 1'b0) begin
      if (rq.size() == 0) chk(1'b0, "unexpected read");
      else chk({pslverr, prdata} === rq.pop_front(), "read mismatch");
    end
  end
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rd(12'h000, 32'h1, 1'b0);
    rd(12'h004, 32'h3E8, 1'b0);
    rd(sa(0, bvs_pkg::W_MAX), 32'hFF, 1'b0);
    rd(sa(0, bvs_pkg::W_STEP), 32'h1, 1'b0);
    rd(12'hC00, 32'h0, 1'b1);
    apb(1'b1, 12'h004, 32'h3);
    v0 = 8'($random(seed));
    v1 = 8'($random(seed));
    for (int k = 0; k < 12; k++) lst[k] = 8'($random(seed));
    apb(1'b1, sa(2, bvs_pkg::W_FIX_TOP), {24'h0, v0});
    apb(1'b1, sa(2, bvs_pkg::W_FIX_BOT), {24'h0, v1});
    exp(2, v0);
    press(1'b1, 2);
    exp(2, v1);
    press(1'b0, 2);
    press(1'b1, 20);
    apb(1'b1, sa(3, bvs_pkg::W_CFG), 32'h11);
    apb(1'b1, sa(9, bvs_pkg::W_CFG), 32'h82);
    apb(1'b1, sa(3, bvs_pkg::W_FIX_TOP), {24'h0, v1});
    apb(1'b1, sa(9, bvs_pkg::W_FIX_TOP), {24'h0, v0});
    exp(3, v1);
    press(1'b1, 3);
    exp(9, v0);
    press(1'b1, 9);
    // delay on: three scrolls, then only the last value after release and expiry
    wlist(4);
    apb(1'b1, sa(4, bvs_pkg::W_CFG), 32'h441);
    exp(4, lst[3]);
    repeat (3) press(1'b1, 4);
    repeat (4) @(posedge i_clock);
    chk(tq.size() == 1 && disp === lst[3], "early send or display");
    drain();
    apb(1'b1, 12'h000, 32'h0);
    exp(4, lst[0]);
    press(1'b1, 4);
    exp(4, lst[1]);
    press(1'b1, 4);
    exp(4, lst[0]);
    press(1'b0, 4);
    for (int r = 0; r < 3; r++) begin
      wlist(tn[r]);
      apb(1'b1, sa(tn[r], bvs_pkg::W_CFG), 32'(1 + (tf[r] << 4) + (tl[r] << 8)));
      for (int k = 1; k <= tc[r]; k++) begin
        exp(tn[r], lst[k % tc[r]]);
        press(1'b1, tn[r]);
      end
    end
    apb(1'b1, sa(6, bvs_pkg::W_CFG), 32'h52);
    apb(1'b1, sa(6, bvs_pkg::W_MIN), 32'h10);
    apb(1'b1, sa(6, bvs_pkg::W_MAX), 32'h1A);
    apb(1'b1, sa(6, bvs_pkg::W_STEP), 32'h4);
    apb(1'b1, sa(6, bvs_pkg::W_VALUE), 32'h10);
    for (int k = 0; k < 6; k++) begin
      exp(6, mv[k]);
      press(k < 3, 6);
    end
    drain();
    rd(sa(6, bvs_pkg::W_VALUE), 32'h10, 1'b0);
    rd(sa(0, 5'h07), 32'h0, 1'b1);
    chk(cnt === 16'(sent) && peek === 8'h10, "receiver count or level");
    final_report();
  end
endmodule : tb
